/* hdl/nufoc_defs.vh */
// Command codes, feature addresses, field positions and timing for the NAND feature host.
// Assumes a 125 MHz controller clock and a byte-wide NAND pin interface.
`ifndef NUFOC_DEFS_VH
`define NUFOC_DEFS_VH
// ==========================================================
// Commands
`define NUFOC_CMD_UID_READ 8'hed
`define NUFOC_CMD_SET_FEAT 8'hef
`define NUFOC_CMD_GET_FEAT 8'hee
`define NUFOC_CMD_STATUS 8'h70
`define NUFOC_CMD_READ 8'h00
`define NUFOC_CMD_COL_CHG1 8'h05
`define NUFOC_CMD_COL_CHG2 8'he0
`define NUFOC_CMD_RESET 8'hff
`define NUFOC_UID_ADDR 8'h00
// ==========================================================
// Feature registers
`define NUFOC_FA_ARRAY_MODE 8'h90
`define NUFOC_FA_BLOCK_PROT 8'ha0
`define NUFOC_ARRAY_MODE_RST 8'h00
`define NUFOC_BLOCK_PROT_RST 8'h38
`define NUFOC_MODE_NORMAL 8'h00
`define NUFOC_MODE_OTP 8'h01
`define NUFOC_MODE_OTP_PROT 8'h03
`define NUFOC_BP_LOCK_BIT 0
`define NUFOC_BP_RANGE_LSB 3
`define NUFOC_BP_RANGE_MSB 5
// ==========================================================
// Unique identifier layout
`define NUFOC_UID_COPY_BYTES 32
`define NUFOC_UID_HALF_BYTES 16
`define NUFOC_UID_COPIES 16
`define NUFOC_UID_OK 8'hff
// ==========================================================
// Timing, in ns, and derived cycles at 8 ns
`define NUFOC_CLK_NS 8
`define NUFOC_T_PULSE_NS 25
`define NUFOC_PULSE_CYC ((`NUFOC_T_PULSE_NS + `NUFOC_CLK_NS - 1) / `NUFOC_CLK_NS)
`define NUFOC_T_WB_NS 100
`define NUFOC_WB_CYC ((`NUFOC_T_WB_NS + `NUFOC_CLK_NS - 1) / `NUFOC_CLK_NS)
`endif

/* hdl/nufoc_host.v */
// Host controller issuing unique-ID read, Set Feature and Get Feature to a NAND device.
// Assumes the device's pins are wired directly; ready/busy and data inputs are asynchronous.
// Contract
// - Identifier read is command EDh then one address cycle 00h.
// - Host XORs each copy's halves; FFh validates, else tries next copy.
// - Column change 05h then E0h is recommended for moving output position.
// - Status 70h may poll; read 00h must follow before data resumes.
// - Set Feature is EFh, one address, then four parameter bytes.
// - Get Feature is EEh and address; device outputs four bytes.
// - Writing 00h to array mode at 90h leaves OTP modes.
`timescale 1ns/1ps
`include "nufoc_defs.vh"
module nufoc_host
(
  input wire mclk,
  input wire reset,
  input wire [1:0] op_cmd,
  input wire [7:0] op_feat_addr,
  input wire [31:0] op_params,
  input wire op_valid,
  output wire op_ready,
  output reg op_done_reg,
  output reg op_refused_reg,
  output reg uid_ok_reg,
  output reg [4:0] uid_copy_reg,
  output reg [7:0] status_reg,
  output wire [7:0] rd_data,
  output wire rd_valid,
  input wire rd_ready,
  output reg nand_cle_reg,
  output reg nand_ale_reg,
  output reg nand_we_n_reg,
  output reg nand_re_n_reg,
  output reg nand_ce_n_reg,
  output reg [7:0] nand_dq_out_reg,
  output reg nand_dq_oe_reg,
  input wire [7:0] nand_dq_in,
  input wire nand_ready_busy_n
);
// ==========================================================
// Operation codes and states
localparam OP_UID = 2'd0;
localparam OP_SET = 2'd1;
localparam OP_GET = 2'd2;
localparam OP_STAT = 2'd3;
localparam S_IDLE = 4'd0;
localparam S_CMD = 4'd1;
localparam S_ADDR = 4'd2;
localparam S_WDATA = 4'd3;
localparam S_WAITB = 4'd4;
localparam S_BUSY = 4'd5;
localparam S_RDCMD = 4'd6;
localparam S_READ = 4'd7;
localparam S_STCMD = 4'd8;
localparam S_STRD = 4'd9;
localparam S_DONE = 4'd10;
// ==========================================================
// Pin synchronisers
reg [7:0] dq_meta_reg;
reg [7:0] dq_sync_reg;
reg rb_meta_reg;
reg rb_sync_reg;
always @(posedge mclk or posedge reset)
begin
  if (reset)
  begin
    dq_meta_reg <= 8'h00;
    dq_sync_reg <= 8'h00;
    rb_meta_reg <= 1'b0;
    rb_sync_reg <= 1'b0;
  end
  else
  begin
    dq_meta_reg <= nand_dq_in;
    dq_sync_reg <= dq_meta_reg;
    rb_meta_reg <= nand_ready_busy_n;
    rb_sync_reg <= rb_meta_reg;
  end
end
// ==========================================================
// Two-entry output buffer
reg [7:0] buf_mem_reg [0:1];
reg [1:0] buf_cnt_reg;
reg buf_wr_reg;
reg buf_rd_reg;
wire buf_full = (buf_cnt_reg == 2'd2);
wire buf_push;
wire buf_pop = rd_valid && rd_ready;
assign rd_valid = (buf_cnt_reg != 2'd0);
assign rd_data = buf_mem_reg[buf_rd_reg];
// ==========================================================
// Sequencer
reg [3:0] state_reg;
reg [1:0] op_reg;
reg [7:0] faddr_reg;
reg [31:0] params_reg;
reg [8:0] idx_reg;
reg [3:0] tick_reg;
reg phase_reg;
reg [7:0] cmd_reg;
reg [7:0] half_reg [0:15];
reg copy_bad_reg;
reg strap_reg;
localparam integer PULSE_CYC = `NUFOC_PULSE_CYC;
localparam integer WB_CYC = `NUFOC_WB_CYC;
wire step = (tick_reg == 4'd0);
assign op_ready = (state_reg == S_IDLE);
// Bytes stream in order from the start, so no column change is ever issued
wire [8:0] read_last = (op_reg == OP_UID) ? 9'd511 : 9'd3;
// Read bytes are pushed only when the buffer has room; the read strobe stalls otherwise
assign buf_push = (state_reg == S_READ) && phase_reg && step && !buf_full;
function feat_ok;
  input [7:0] a;
  input s;
  begin
    feat_ok = (a == `NUFOC_FA_ARRAY_MODE) || ((a == `NUFOC_FA_BLOCK_PROT) && s);
  end
endfunction
always @(posedge mclk or posedge reset)
begin
  if (reset)
  begin
    strap_reg <= 1'b0;
    buf_cnt_reg <= 2'd0;
    buf_wr_reg <= 1'b0;
    buf_rd_reg <= 1'b0;
    buf_mem_reg[0] <= 8'h00;
    buf_mem_reg[1] <= 8'h00;
  end
  else
  begin
    strap_reg <= 1'b1;
    if (buf_push)
    begin
      buf_mem_reg[buf_wr_reg] <= dq_sync_reg;
      buf_wr_reg <= ~buf_wr_reg;
    end
    if (buf_pop)
      buf_rd_reg <= ~buf_rd_reg;
    buf_cnt_reg <= buf_cnt_reg + {1'b0, buf_push} - {1'b0, buf_pop};
  end
end
genvar g;
generate
  for (g = 0; g < 16; g = g + 1)
  begin : g_half
    always @(posedge mclk or posedge reset)
    begin
      if (reset)
        half_reg[g] <= 8'h00;
      else if (buf_push && (op_reg == OP_UID) && !idx_reg[4] && (idx_reg[3:0] == g))
        half_reg[g] <= dq_sync_reg;
    end
  end
endgenerate
always @(posedge mclk or posedge reset)
begin
  if (reset)
  begin
    state_reg <= S_IDLE;
    op_reg <= OP_UID;
    faddr_reg <= 8'h00;
    params_reg <= 32'h0;
    idx_reg <= 9'd0;
    tick_reg <= 4'd0;
    phase_reg <= 1'b0;
    cmd_reg <= 8'h00;
    copy_bad_reg <= 1'b0;
    op_done_reg <= 1'b0;
    op_refused_reg <= 1'b0;
    uid_ok_reg <= 1'b0;
    uid_copy_reg <= 5'd0;
    status_reg <= 8'h00;
    nand_cle_reg <= 1'b0;
    nand_ale_reg <= 1'b0;
    nand_we_n_reg <= 1'b1;
    nand_re_n_reg <= 1'b1;
    nand_ce_n_reg <= 1'b1;
    nand_dq_out_reg <= 8'h00;
    nand_dq_oe_reg <= 1'b0;
  end
  else
  begin
    op_done_reg <= 1'b0;
    op_refused_reg <= 1'b0;
    if (!step)
      tick_reg <= tick_reg - 4'd1;
    case (state_reg)
      S_IDLE:
      begin
        nand_ce_n_reg <= 1'b1;
        if (op_valid)
        begin
          op_reg <= op_cmd;
          faddr_reg <= op_feat_addr;
          params_reg <= op_params;
          idx_reg <= 9'd0;
          phase_reg <= 1'b0;
          copy_bad_reg <= 1'b0;
          // Refused here so the device never sees an invalid feature write
          if (op_cmd == OP_SET && !feat_ok(op_feat_addr, strap_reg))
            op_refused_reg <= 1'b1;
          else
          begin
            nand_ce_n_reg <= 1'b0;
            state_reg <= (op_cmd == OP_STAT) ? S_STCMD : S_CMD;
            cmd_reg <= (op_cmd == OP_UID) ? `NUFOC_CMD_UID_READ :
              (op_cmd == OP_SET) ? `NUFOC_CMD_SET_FEAT : `NUFOC_CMD_GET_FEAT;
            if (op_cmd == OP_UID)
              uid_ok_reg <= 1'b0;
          end
        end
      end
      S_CMD, S_ADDR, S_WDATA, S_RDCMD, S_STCMD:
      if (step)
      begin
        // Write strobe: low for one pulse width, then high for one
        nand_cle_reg <= (state_reg == S_CMD) || (state_reg == S_RDCMD) || (state_reg == S_STCMD);
        nand_ale_reg <= (state_reg == S_ADDR);
        nand_dq_oe_reg <= 1'b1;
        tick_reg <= PULSE_CYC[3:0];
        phase_reg <= ~phase_reg;
        nand_we_n_reg <= phase_reg;
        if (state_reg == S_CMD)
          nand_dq_out_reg <= cmd_reg;
        else if (state_reg == S_RDCMD)
          nand_dq_out_reg <= `NUFOC_CMD_READ;
        else if (state_reg == S_STCMD)
          nand_dq_out_reg <= `NUFOC_CMD_STATUS;
        else if (state_reg == S_ADDR)
          nand_dq_out_reg <= (op_reg == OP_UID) ? `NUFOC_UID_ADDR : faddr_reg;
        else
          nand_dq_out_reg <= params_reg[idx_reg[1:0]*8 +: 8];
        if (phase_reg)
        begin
          case (state_reg)
            S_CMD: state_reg <= S_ADDR;
            S_ADDR: state_reg <= (op_reg == OP_SET) ? S_WDATA : S_WAITB;
            S_WDATA:
            begin
              idx_reg <= idx_reg + 9'd1;
              if (idx_reg[1:0] == 2'd3)
                state_reg <= S_WAITB;
            end
            S_RDCMD: state_reg <= S_READ;
            S_STCMD: state_reg <= S_STRD;
            default: state_reg <= S_IDLE;
          endcase
        end
      end
      S_WAITB:
      begin
        nand_cle_reg <= 1'b0;
        nand_ale_reg <= 1'b0;
        nand_dq_oe_reg <= 1'b0;
        tick_reg <= WB_CYC[3:0];
        state_reg <= S_BUSY;
      end
      S_BUSY:
      if (step && rb_sync_reg)
      begin
        idx_reg <= 9'd0;
        // Set Feature ends here; reads re-enable output with 00h after polling
        state_reg <= (op_reg == OP_SET) ? S_DONE : S_RDCMD;
      end
      S_READ:
      begin
        nand_cle_reg <= 1'b0;
        nand_dq_oe_reg <= 1'b0;
        if (step && (!phase_reg || !buf_full))
        begin
          tick_reg <= PULSE_CYC[3:0];
          phase_reg <= ~phase_reg;
          nand_re_n_reg <= phase_reg;
          if (phase_reg)
          begin
            idx_reg <= idx_reg + 9'd1;
            if (op_reg == OP_UID && idx_reg[4])
            begin
              if ((half_reg[idx_reg[3:0]] ^ dq_sync_reg) != `NUFOC_UID_OK)
                copy_bad_reg <= 1'b1;
              if (idx_reg[3:0] == 4'hf)
              begin
                if (!copy_bad_reg && ((half_reg[15] ^ dq_sync_reg) == `NUFOC_UID_OK)
                    && !uid_ok_reg)
                begin
                  uid_ok_reg <= 1'b1;
                  uid_copy_reg <= {1'b0, idx_reg[8:5]};
                end
                copy_bad_reg <= 1'b0;
              end
            end
            if (idx_reg == read_last)
              state_reg <= S_DONE;
          end
        end
      end
      S_STRD:
      if (step)
      begin
        nand_cle_reg <= 1'b0;
        nand_dq_oe_reg <= 1'b0;
        tick_reg <= PULSE_CYC[3:0];
        phase_reg <= ~phase_reg;
        nand_re_n_reg <= phase_reg;
        if (phase_reg)
        begin
          status_reg <= dq_sync_reg;
          state_reg <= S_DONE;
        end
      end
      S_DONE:
      begin
        nand_ce_n_reg <= 1'b1;
        op_done_reg <= 1'b1;
        state_reg <= S_IDLE;
      end
      default: state_reg <= S_IDLE;
    endcase
  end
end
endmodule

/* sim/nufoc_host_props.sv */
// Checker for the user ports and NAND pins of nufoc_host.
// Assumes it is bound into every instance of nufoc_host.
`timescale 1ns/1ps
module nufoc_host_props
(
  input wire mclk,
  input wire reset,
  input wire [1:0] op_cmd,
  input wire [7:0] op_feat_addr,
  input wire op_valid,
  input wire op_ready,
  input wire op_done_reg,
  input wire op_refused_reg,
  input wire [7:0] rd_data,
  input wire rd_valid,
  input wire rd_ready,
  input wire nand_cle_reg,
  input wire nand_ale_reg,
  input wire nand_we_n_reg,
  input wire nand_re_n_reg,
  input wire nand_ce_n_reg,
  input wire [7:0] nand_dq_out_reg,
  input wire nand_dq_oe_reg
);
  // ====
  // Properties
  default clocking @(posedge mclk);
  endclocking
  default disable iff (reset);
  wire set_take = op_valid && op_ready && op_cmd == 2'h1;
  wire fa_ok = op_feat_addr == 8'h90 || op_feat_addr == 8'ha0;
  a_refuse_bad_addr: assert property (set_take && !fa_ok |=> op_refused_reg)
    else $error("reserved feature address not refused");
  a_accept_good_addr: assert property (set_take && fa_ok |=> !op_refused_reg)
    else $error("valid feature address refused");
  a_cmd_code_legal: assert property (!nand_we_n_reg && nand_cle_reg |->
    nand_dq_out_reg inside {8'hed, 8'hef, 8'hee, 8'h70, 8'h00}) else $error("bad command byte");
  a_addr_code_legal: assert property (!nand_we_n_reg && nand_ale_reg |->
    nand_dq_out_reg inside {8'h00, 8'h90, 8'ha0}) else $error("bad address byte");
  a_host_drives: assert property (!nand_we_n_reg |-> nand_dq_oe_reg && !nand_ce_n_reg)
    else $error("write strobe without driven bus");
  a_read_released: assert property (!nand_re_n_reg |-> !nand_dq_oe_reg && nand_we_n_reg)
    else $error("bus driven during read strobe");
  a_strobe_width: assert property ($fell(nand_we_n_reg) |-> !nand_we_n_reg [*4])
    else $error("write strobe too short");
  a_done_single: assert property (op_done_reg |=> !op_done_reg)
    else $error("done longer than one cycle");
  a_rd_hold: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_data))
    else $error("stalled byte lost or changed");
endmodule
bind nufoc_host nufoc_host_props chk (.mclk(mclk), .reset(reset), .op_cmd(op_cmd),
  .op_feat_addr(op_feat_addr), .op_valid(op_valid), .op_ready(op_ready),
  .op_done_reg(op_done_reg), .op_refused_reg(op_refused_reg), .rd_data(rd_data),
  .rd_valid(rd_valid), .rd_ready(rd_ready), .nand_cle_reg(nand_cle_reg),
  .nand_ale_reg(nand_ale_reg), .nand_we_n_reg(nand_we_n_reg), .nand_re_n_reg(nand_re_n_reg),
  .nand_ce_n_reg(nand_ce_n_reg), .nand_dq_out_reg(nand_dq_out_reg),
  .nand_dq_oe_reg(nand_dq_oe_reg));

/* sim/nufoc_dev_model.sv */
// Behavioural NAND device: identifier read, feature set and get, status.
// Assumes the protection strap is high; clockless, reacts to strobe edges.
`timescale 1ns/1ps
module nufoc_dev_model
(
  input wire ce_n,
  input wire cle,
  input wire ale,
  input wire we_n,
  input wire re_n,
  input wire [7:0] host_dq,
  input wire host_oe,
  input wire slow,
  output wire [7:0] dq_bus,
  output reg rb_n
);
  reg [7:0] mode = 8'h00;
  reg [7:0] fa = 8'h00;
  reg [7:0] amode = 8'h00;
  reg [7:0] bprot = 8'h38;
  reg [7:0] p1 = 8'h00;
  reg [7:0] last = 8'h00;
  reg stat = 1'b0;
  reg lock = 1'b0;
  reg [8:0] idx = 9'h000;
  reg [1:0] cnt = 2'h0;
  wire [7:0] d = {idx[8:5], idx[3:0]} ^ 8'h5a;
  // Copy 0 is corrupt on purpose so the host must fall through to copy 1
  wire [7:0] ubyte = (idx[4] && idx[8:5] != 4'h0) ? ~d : d;
  wire [7:0] fbyte = idx != 9'h000 ? 8'h00 : fa == 8'h90 ? amode :
    fa == 8'ha0 ? bprot : 8'h00;
  wire [7:0] rbyte = stat ? {1'b1, rb_n, rb_n, 5'h00} : mode == 8'hed ? ubyte : fbyte;
  // Released bus shows the inverse of the last byte, never a held copy
  assign dq_bus = host_oe ? host_dq : (!ce_n && !re_n) ? rbyte : ~last;
  initial rb_n = 1'b1;
  task go_busy;
    begin
      rb_n = 1'b0;
      rb_n <= #(slow ? 2000 : 120) 1'b1;
    end
  endtask
  always @(posedge re_n)
    if (!ce_n)
    begin
      last = rbyte;
      idx = idx + 9'h001;
    end
  // Feature bytes are only written here, so a reset command leaves them alone
  always @(posedge we_n)
    if (!ce_n && cle)
    begin
      stat = host_dq == 8'h70;
      if (host_dq == 8'hed || host_dq == 8'hee || host_dq == 8'hef)
      begin
        mode = host_dq;
        cnt = 2'h0;
      end
    end
    else if (!ce_n && ale)
    begin
      fa = host_dq;
      idx = 9'h000;
      if (mode != 8'hef)
        go_busy;
    end
    else if (!ce_n && mode == 8'hef)
    begin
      if (cnt == 2'h0)
        p1 = host_dq;
      if (cnt == 2'h3)
      begin
        if (fa == 8'h90)
          amode = p1;
        if (fa == 8'ha0 && !lock)
        begin
          bprot = p1;
          lock = p1[0];
        end
        go_busy;
      end
      cnt = cnt + 2'h1;
    end
endmodule

/* sim/nufoc_host_tb.sv */
// Self-checking bench for nufoc_host against the behavioural NAND device.
// Assumes the design, its header, the model and the checker are compiled.
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; $display("ERROR %s expected %h seen %h", n, e, g); end end
module nufoc_host_tb;
  reg mclk = 1'b0;
  reg reset = 1'b1;
  reg [1:0] op_cmd = 2'h0;
  reg [7:0] op_feat_addr = 8'h00;
  reg [31:0] op_params = 32'h00000000;
  reg op_valid = 1'b0;
  reg rd_ready = 1'b1;
  reg slow = 1'b0;
  wire op_ready, op_done_reg, op_refused_reg, uid_ok_reg, rd_valid, rb_n;
  wire cle, ale, we_n, re_n, ce_n, oe;
  wire [4:0] uid_copy_reg;
  wire [7:0] status_reg, rd_data, dq_out, dq_bus;
  int mismatches = 0;
  int comparisons = 0;
  logic [7:0] got [$];
  logic refd;
  // Rows: command, feature address, first parameter, expected byte
  logic [25:0] rows [0:13] = '{{2'h2, 8'h90, 8'h00, 8'h00}, {2'h2, 8'ha0, 8'h00, 8'h38},
    {2'h1, 8'h90, 8'h01, 8'h00}, {2'h2, 8'h90, 8'h00, 8'h01}, {2'h3, 8'h00, 8'h00, 8'he0},
    {2'h1, 8'h90, 8'h03, 8'h00}, {2'h2, 8'h90, 8'h00, 8'h03}, {2'h1, 8'h90, 8'h00, 8'h00},
    {2'h2, 8'h90, 8'h00, 8'h00}, {2'h1, 8'ha0, 8'h10, 8'h00}, {2'h2, 8'ha0, 8'h00, 8'h10},
    {2'h1, 8'ha0, 8'h29, 8'h00}, {2'h1, 8'ha0, 8'h38, 8'h00}, {2'h2, 8'ha0, 8'h00, 8'h29}};
  always #4 mclk = ~mclk;
  nufoc_host uut (.mclk(mclk), .reset(reset), .op_cmd(op_cmd), .op_feat_addr(op_feat_addr),
    .op_params(op_params), .op_valid(op_valid), .op_ready(op_ready), .op_done_reg(op_done_reg),
    .op_refused_reg(op_refused_reg), .uid_ok_reg(uid_ok_reg), .uid_copy_reg(uid_copy_reg),
    .status_reg(status_reg), .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .nand_cle_reg(cle), .nand_ale_reg(ale), .nand_we_n_reg(we_n), .nand_re_n_reg(re_n),
    .nand_ce_n_reg(ce_n), .nand_dq_out_reg(dq_out), .nand_dq_oe_reg(oe), .nand_dq_in(dq_bus),
    .nand_ready_busy_n(rb_n));
  nufoc_dev_model dev (.ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n),
    .host_dq(dq_out), .host_oe(oe), .slow(slow), .dq_bus(dq_bus), .rb_n(rb_n));
  function automatic logic [7:0] uid_exp(input logic [8:0] i);
    logic [7:0] d;
    begin
      d = {i[8:5], i[3:0]} ^ 8'h5a;
      uid_exp = (i[4] && i[8:5] != 4'h0) ? ~d : d;
    end
  endfunction
  task automatic close_out;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  // A stalled run drops rd_ready for four cycles in every eight
  task automatic run_op(input logic [1:0] c, input logic [7:0] a, input logic [7:0] p,
    input bit stall, input int n);
    bit fin;
    begin
      fin = 1'b0;
      refd = 1'b0;
      got.delete();
      @(posedge mclk);
      op_cmd <= c;
      op_feat_addr <= a;
      op_params <= {24'h000000, p};
      op_valid <= 1'b1;
      @(posedge mclk);
      op_valid <= 1'b0;
      for (int k = 0; !(fin && got.size() >= n); k++)
      begin
        if (k > 40000)
        begin
          mismatches++;
          close_out();
        end
        #1;
        if (rd_valid === 1'b1 && rd_ready === 1'b1)
          got.push_back(rd_data);
        if (op_refused_reg === 1'b1)
          refd = 1'b1;
        if (op_done_reg === 1'b1 || refd)
          fin = 1'b1;
        @(posedge mclk);
        rd_ready <= !stall || k[2] || (fin && got.size() >= n);
      end
    end
  endtask
  initial
  begin
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    for (int i = 0; i < 14; i++)
    begin
      run_op(rows[i][25:24], rows[i][23:16], rows[i][15:8], 1'b0, (rows[i][25:24] == 2'h2) ? 4 : 0);
      if (rows[i][25:24] == 2'h2)
      begin
        `CHK("feature byte", rows[i][7:0], got[0])
        `CHK("upper bytes", 24'h000000, {got[1], got[2], got[3]})
      end
      else if (rows[i][25:24] == 2'h3)
        `CHK("status", rows[i][7:0], status_reg)
      else
        `CHK("set accepted", 1'b0, refd)
    end
    run_op(2'h1, 8'h91, 8'h55, 1'b0, 0);
    `CHK("reserved refused", 1'b1, refd)
    slow <= 1'b1;
    run_op(2'h0, 8'h00, 8'h00, 1'b1, 512);
    for (int i = 0; i < 512; i++)
      `CHK("uid byte", uid_exp(i[8:0]), got[i])
    `CHK("uid ok", 1'b1, uid_ok_reg)
    `CHK("uid copy", 5'h01, uid_copy_reg)
    slow <= 1'b0;
    @(posedge mclk);
    op_cmd <= 2'h0;
    op_valid <= 1'b1;
    @(posedge mclk);
    op_valid <= 1'b0;
    repeat (200) @(posedge mclk);
    reset <= 1'b1;
    @(posedge mclk);
    #1;
    `CHK("idle in reset", 8'h87, {op_ready, rd_valid, oe, cle, ale, we_n, re_n, ce_n})
    @(posedge mclk);
    reset <= 1'b0;
    run_op(2'h2, 8'ha0, 8'h00, 1'b0, 4);
    `CHK("kept protection", 8'h29, got[0])
    close_out();
  end
endmodule
